// >>> ccs_cfg.svh
// Purpose: Offsets, field positions, reset values for the capture/compare status block
// Assumes: Included by the design files by bare name
// Notes:   Definitions only
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define CCS_ADDR_W       3
`define CCS_DATA_W       16
`define CCS_REG_W        8

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CCS_OFF_STATUS   3'h0
`define CCS_OFF_IOCTL    3'h1
`define CCS_OFF_IRQEN    3'h2
`define CCS_OFF_COUNT    3'h3
`define CCS_OFF_GR_BASE  3'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCS_BIT_OVF      7
`define CCS_BIT_B_FUNC   6
`define CCS_BIT_B_ACT_HI 5
`define CCS_BIT_B_ACT_LO 4
`define CCS_BIT_A_FUNC   2
`define CCS_BIT_A_ACT_HI 1
`define CCS_BIT_A_ACT_LO 0
`define CCS_NUM_GR       4

// ----------------------------------------------------------------
// Reserved masks and reset values
// ----------------------------------------------------------------
`define CCS_STATUS_RSVD  8'h70
`define CCS_IOCTL_RSVD   8'h88
`define CCS_IRQEN_RSVD   8'h70
`define CCS_IOCTL_RST    8'h00
`define CCS_IRQEN_RST    8'h00
`define CCS_COUNT_RST    16'h0000
`define CCS_COUNT_MAX    16'hffff
`define CCS_GR_RST       16'hffff

`endif

// >>> ccs_pkg.sv
// Purpose: Shared types for the capture/compare status block
// Assumes: Nothing
// Notes:   Action and edge encodings of the two-bit channel field
package ccs_pkg;

  typedef enum logic [1:0]
  {
    CCS_ACT_NONE   = 2'h0,
    CCS_ACT_LOW    = 2'h1,
    CCS_ACT_HIGH   = 2'h2,
    CCS_ACT_TOGGLE = 2'h3
  } ccs_action_t;

  typedef enum logic [1:0]
  {
    CCS_EDGE_RISE  = 2'h0,
    CCS_EDGE_FALL  = 2'h1,
    CCS_EDGE_BOTH  = 2'h2
  } ccs_edge_t;

endpackage : ccs_pkg

// >>> ccs_event_flag.sv
// Purpose: One sticky status flag with read-then-write-0 clear
// Assumes: Read and write strobes never in one cycle
// Notes:   Set beats clear in the same cycle
`timescale 1ns/10ps
`include "ccs_cfg.svh"

module ccs_event_flag
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sysRst,
  // Events and access
  input  wire logic setEvent,
  input  wire logic statusRead,
  input  wire logic statusWrite,
  input  wire logic wrBit,
  // State
  output logic      flag
);
  import ccs_pkg::*;

  logic flag_q;
  logic flag_d;
  logic armed_q;
  logic armed_d;
  wire  clearOk = statusWrite & ~wrBit & armed_q;

  // Arm only by a read that saw the flag set; any write disarms
  assign armed_d = statusWrite ? 1'b0 : (statusRead & flag_q) ? 1'b1 : armed_q;
  assign flag_d  = setEvent ? 1'b1 : clearOk ? 1'b0 : flag_q;
  assign flag    = flag_q;

  always_ff @(posedge clk)
  begin
    if (sysRst)
    begin
      flag_q  <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      flag_q  <= flag_d;
      armed_q <= armed_d;
    end
  end

endmodule : ccs_event_flag

// >>> ccs_channel.sv
// Purpose: One general register with compare match and input capture
// Assumes: Pin input synchronous to clk
// Notes:   Without a pin the channel is compare-only and never drives
`timescale 1ns/10ps
`include "ccs_cfg.svh"

module ccs_channel
#(
  parameter int WIDTH   = 16,
  parameter bit HAS_PIN = 1'b1
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sysRst,
  // Timer state and control
  input  wire logic [WIDTH-1:0] counter,
  input  wire logic             captureMode,
  input  wire logic [1:0]       pinMode,
  // Software write
  input  wire logic             grWrite,
  input  wire logic [WIDTH-1:0] grWrData,
  // Pin
  input  wire logic             pinIn,
  output logic                  pinOut,
  output logic                  pinOe,
  // Results
  output logic [WIDTH-1:0]      grValue,
  output logic                  event_
);
  import ccs_pkg::*;

  logic [WIDTH-1:0] gr_q;
  logic [WIDTH-1:0] gr_d;
  logic             pinPrev_q;
  logic             pinOut_q;
  logic             pinOut_d;
  logic             pinOe_q;

  wire capMode  = HAS_PIN & captureMode;
  wire rise     = pinIn & ~pinPrev_q;
  wire fall     = ~pinIn & pinPrev_q;
  // Upper field bit alone selects both edges
  wire edgeHit  = pinMode[1] ? (rise | fall)
                : (pinMode[0] ? fall : rise);
  wire capture  = capMode & edgeHit;
  wire match    = ~capMode & (counter == gr_q);

  // Capture beats a software write in the same cycle
  assign gr_d = capture ? counter : grWrite ? grWrData : gr_q;

  // Low or high on a pin already there leaves it unchanged
  always_comb
  begin
    pinOut_d = pinOut_q;
    if (match & HAS_PIN)
    begin
      case (ccs_action_t'(pinMode))
        CCS_ACT_NONE:   pinOut_d = pinOut_q;
        CCS_ACT_LOW:    pinOut_d = 1'b0;
        CCS_ACT_HIGH:   pinOut_d = 1'b1;
        CCS_ACT_TOGGLE: pinOut_d = ~pinOut_q;
        default:        pinOut_d = pinOut_q;
      endcase
    end
  end

  assign event_  = capture | match;
  assign grValue = gr_q;
  assign pinOut  = pinOut_q;
  assign pinOe   = pinOe_q;

  always_ff @(posedge clk)
  begin
    if (sysRst)
    begin
      gr_q      <= `CCS_GR_RST;
      pinPrev_q <= 1'b0;
      pinOut_q  <= 1'b0;
      pinOe_q   <= 1'b0;
    end
    else
    begin
      gr_q      <= gr_d;
      pinPrev_q <= pinIn;
      pinOut_q  <= pinOut_d;
      pinOe_q   <= HAS_PIN & ~captureMode & (pinMode != 2'h0);
    end
  end

endmodule : ccs_channel

// >>> ccs_timer_status.sv
// Purpose: Counter, status flags, channel A/B I/O control and request lines
// Assumes: Single clock, synchronous inputs, one-cycle register strobes
// Notes:   Counter runs every clock; channels C and D are compare-only
//
// What this block does
// - Set overflow flag when counter wraps to zero
// - Overflow clears by read-as-1 then write 0
// - Status bits 6..4 always read 1
// - Compare mode: flag set on counter equal
// - Capture mode: copy counter on edge, set flag
// - Flags D..A at bits 3..0, overflow bit 7
// - Event flags clear by read-as-1 then write 0
// - Control bit 6 picks compare or capture B
// - Control bit 2 picks compare or capture A
// - Channel B action: none, low, high, toggle
// - Channel B capture edge: rise, fall, both
// - Channel A action: none, low, high, toggle
// - Channel A capture edge: rise, fall, both
// - Control bits 7, 3 read 1; others reset 0
// - Overflow request only when enabled and flagged
// - Each event request gated by its enable
// - Toggle action is field value 11
// - Pin already at level stays unchanged
//
// Word map: 0 status, 1 io control A/B, 2 request enables,
// 3 up counter, 4..7 general registers A..D
// Upper byte of the 8-bit registers reads 0
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "ccs_cfg.svh"

module ccs_timer_status
#(
  parameter int AW = `CCS_ADDR_W,
  parameter int DW = `CCS_DATA_W
)
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          sysRst,
  // Register port
  input  wire logic [AW-1:0] regAddr,
  input  wire logic [DW-1:0] regWrData,
  input  wire logic          regWrite,
  input  wire logic          regRead,
  output logic      [DW-1:0] regRdData,
  // Timer pin A
  input  wire logic          timerPinAIn,
  output logic               timerPinAOut,
  output logic               timerPinAOe,
  // Timer pin B
  input  wire logic          timerPinBIn,
  output logic               timerPinBOut,
  output logic               timerPinBOe,
  // Request lines
  output logic               overflowIrqRequest,
  output logic [3:0]         eventIrqRequest
);
  import ccs_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DW-1:0]       counter_q;
  logic [DW-1:0]       counter_d;
  logic [7:0]          ioctl_q;
  logic [7:0]          irqEn_q;
  logic [DW-1:0]       rdData_q;
  logic                ovfIrq_q;
  logic [3:0]          evtIrq_q;
  logic [7:0]          ioctl_d;
  logic [7:0]          irqEn_d;
  logic [DW-1:0]       rdData_d;
  logic                ovfIrq_d;
  logic [3:0]          evtIrq_d;

  logic [DW-1:0]       grValue [`CCS_NUM_GR];
  logic [`CCS_NUM_GR-1:0] grEvent;
  logic [`CCS_NUM_GR-1:0] pinOutVec;
  logic [`CCS_NUM_GR-1:0] pinOeVec;
  logic [4:0]          flagVec;
  logic [4:0]          setVec;
  logic [`CCS_NUM_GR-1:0] capModeVec;
  logic [1:0]          pinModeVec [`CCS_NUM_GR];
  logic [`CCS_NUM_GR-1:0] pinInVec;
  logic [`CCS_NUM_GR-1:0] grWrVec;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hitStatus = (regAddr == `CCS_OFF_STATUS);
  wire hitIoctl  = (regAddr == `CCS_OFF_IOCTL);
  wire hitIrqEn  = (regAddr == `CCS_OFF_IRQEN);
  wire hitCount  = (regAddr == `CCS_OFF_COUNT);
  wire hitGr     = (regAddr >= `CCS_OFF_GR_BASE);
  wire [1:0] grSel = 2'(regAddr - `CCS_OFF_GR_BASE);

  wire wrStatus  = regWrite & hitStatus;
  wire rdStatus  = regRead & hitStatus;
  wire wrIoctl   = regWrite & hitIoctl;
  wire wrIrqEn   = regWrite & hitIrqEn;
  wire wrCount   = regWrite & hitCount;

  // One write select per general register
  assign grWrVec[0] = regWrite & hitGr & (grSel == 2'h0);
  assign grWrVec[1] = regWrite & hitGr & (grSel == 2'h1);
  assign grWrVec[2] = regWrite & hitGr & (grSel == 2'h2);
  assign grWrVec[3] = regWrite & hitGr & (grSel == 2'h3);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A software write takes the place of the wrap, so no flag then
  wire wrap      = (counter_q == `CCS_COUNT_MAX) & ~wrCount;
  assign counter_d = wrCount ? regWrData : DW'(counter_q + 1'b1);

  always_ff @(posedge clk)
  begin
    if (sysRst)
      counter_q <= `CCS_COUNT_RST;
    else
      counter_q <= counter_d;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Reserved bits are not stored, they are forced on read
  assign ioctl_d = wrIoctl ? (regWrData[7:0] & ~`CCS_IOCTL_RSVD) : ioctl_q;
  assign irqEn_d = wrIrqEn ? (regWrData[7:0] & ~`CCS_IRQEN_RSVD) : irqEn_q;

  always_ff @(posedge clk)
  begin
    if (sysRst)
      ioctl_q <= `CCS_IOCTL_RST;
    else
      ioctl_q <= ioctl_d;
  end

  always_ff @(posedge clk)
  begin
    if (sysRst)
      irqEn_q <= `CCS_IRQEN_RST;
    else
      irqEn_q <= irqEn_d;
  end

  // Channel A and B fields; C and D are fixed to plain compare
  assign capModeVec[0]  = ioctl_q[`CCS_BIT_A_FUNC];
  assign capModeVec[1]  = ioctl_q[`CCS_BIT_B_FUNC];
  assign capModeVec[2]  = 1'b0;
  assign capModeVec[3]  = 1'b0;
  assign pinModeVec[0]  = ioctl_q[`CCS_BIT_A_ACT_HI:`CCS_BIT_A_ACT_LO];
  assign pinModeVec[1]  = ioctl_q[`CCS_BIT_B_ACT_HI:`CCS_BIT_B_ACT_LO];
  assign pinModeVec[2]  = 2'h0;
  assign pinModeVec[3]  = 2'h0;
  assign pinInVec       = {2'b00, timerPinBIn, timerPinAIn};

  // ----------------------------------------------------------------
  // General registers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `CCS_NUM_GR; gi++)
    begin : g_chan
      ccs_channel
      #(
        .WIDTH   (DW),
        .HAS_PIN (gi < 2)
      )
      u_chan
      (
        .clk         (clk),
        .sysRst      (sysRst),
        .counter     (counter_q),
        .captureMode (capModeVec[gi]),
        .pinMode     (pinModeVec[gi]),
        .grWrite     (grWrVec[gi]),
        .grWrData    (regWrData),
        .pinIn       (pinInVec[gi]),
        .pinOut      (pinOutVec[gi]),
        .pinOe       (pinOeVec[gi]),
        .grValue     (grValue[gi]),
        .event_      (grEvent[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Index 4 is the overflow flag, 3..0 follow the channels
  assign setVec = {wrap, grEvent};

  genvar fi;
  generate
    for (fi = 0; fi < 5; fi++)
    begin : g_flag
      localparam int BITPOS = (fi == 4) ? `CCS_BIT_OVF : fi;
      ccs_event_flag u_flag
      (
        .clk         (clk),
        .sysRst      (sysRst),
        .setEvent    (setVec[fi]),
        .statusRead  (rdStatus),
        .statusWrite (wrStatus),
        .wrBit       (regWrData[BITPOS]),
        .flag        (flagVec[fi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] statusView = {flagVec[4], 3'b000, flagVec[3:0]}
                        | `CCS_STATUS_RSVD;
  wire [7:0] ioctlView  = ioctl_q | `CCS_IOCTL_RSVD;
  wire [7:0] irqEnView  = irqEn_q | `CCS_IRQEN_RSVD;

  wire [DW-1:0] rdMux = hitStatus ? DW'(statusView)
                      : hitIoctl  ? DW'(ioctlView)
                      : hitIrqEn  ? DW'(irqEnView)
                      : hitCount  ? counter_q
                      : hitGr     ? grValue[grSel]
                      : {DW{1'b0}};

  // Data stand only in the cycle after the read strobe
  assign rdData_d = regRead ? rdMux : {DW{1'b0}};

  always_ff @(posedge clk)
  begin
    if (sysRst)
      rdData_q <= {DW{1'b0}};
    else
      rdData_q <= rdData_d;
  end

  // ----------------------------------------------------------------
  // Request lines
  // ----------------------------------------------------------------
  // Registered to keep outputs flop-driven; one cycle behind the flag
  assign ovfIrq_d = flagVec[4] & irqEn_q[`CCS_BIT_OVF];
  assign evtIrq_d = flagVec[3:0] & irqEn_q[3:0];

  always_ff @(posedge clk)
  begin
    if (sysRst)
    begin
      ovfIrq_q <= 1'b0;
      evtIrq_q <= 4'h0;
    end
    else
    begin
      ovfIrq_q <= ovfIrq_d;
      evtIrq_q <= evtIrq_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdData          = rdData_q;
  assign timerPinAOut       = pinOutVec[0];
  assign timerPinAOe        = pinOeVec[0];
  assign timerPinBOut       = pinOutVec[1];
  assign timerPinBOe        = pinOeVec[1];
  assign overflowIrqRequest = ovfIrq_q;
  assign eventIrqRequest    = evtIrq_q;

endmodule : ccs_timer_status

// >>> ccs_timer_status_sva.sv
// Purpose: Port-level checks of the timer status block
// Assumes: Only top ports visible; io control shadowed from writes
// Notes:   Pin checks need the mode held over two cycles
`timescale 1ns/10ps

module ccs_timer_status_sva
#(
  parameter int AW = 3,
  parameter int DW = 16
)
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          sysRst,
  // Register port
  input wire logic [AW-1:0] regAddr,
  input wire logic [DW-1:0] regWrData,
  input wire logic          regWrite,
  input wire logic          regRead,
  input wire logic [DW-1:0] regRdData,
  // Pins
  input wire logic          timerPinAIn,
  input wire logic          timerPinAOut,
  input wire logic          timerPinAOe,
  input wire logic          timerPinBIn,
  input wire logic          timerPinBOut,
  input wire logic          timerPinBOe,
  // Requests
  input wire logic          overflowIrqRequest,
  input wire logic [3:0]    eventIrqRequest
);
  // ------------
  // Helper state
  // ------------
  logic [7:0]    ioCtl_q;
  logic          wasRead_q;
  logic [AW-1:0] lastAddr_q;
  wire logic rdStat = wasRead_q && lastAddr_q == 3'h0;
  wire logic rdIo   = wasRead_q && lastAddr_q == 3'h1;
  wire logic rdEn   = wasRead_q && lastAddr_q == 3'h2;
  wire logic [2:0] aMode = ioCtl_q[2:0];
  wire logic [2:0] bMode = ioCtl_q[6:4];

  always_ff @(posedge clk)
  begin
    wasRead_q  <= regRead & ~sysRst;
    lastAddr_q <= regAddr;
    if (sysRst)
      ioCtl_q <= 8'h00;
    else if (regWrite && regAddr == 3'h1)
      ioCtl_q <= regWrData[7:0];
  end

  // ------------
  // Properties
  // ------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sysRst);

  stat_rsvd_a: assert property (rdStat |-> regRdData[15:8] == 8'h00 && regRdData[6:4] == 3'h7)
    else $error("status reserved bits wrong");
  io_view_a: assert property (rdIo |-> regRdData == {8'h00, 1'b1, bMode, 1'b1, aMode})
    else $error("io control readback wrong");
  ovf_gate_a: assert property (rdStat && !regRdData[7] |-> !overflowIrqRequest)
    else $error("overflow request without flag");
  evt_gate_a: assert property (rdStat |-> (eventIrqRequest & ~regRdData[3:0]) == 4'h0)
    else $error("event request without flag");
  en_gate_a: assert property (rdEn |-> (eventIrqRequest & ~regRdData[3:0]) == 4'h0
    && (regRdData[7] || !overflowIrqRequest)) else $error("request while disabled");
  oe_a_a: assert property (rdIo |-> timerPinAOe == (!regRdData[2] && regRdData[1:0] != 2'h0))
    else $error("pin A enable wrong");
  oe_b_a: assert property (rdIo |-> timerPinBOe == (!regRdData[6] && regRdData[5:4] != 2'h0))
    else $error("pin B enable wrong");
  a_none_a: assert property (aMode == 3'h0 && $past(aMode) == 3'h0 |-> $stable(timerPinAOut))
    else $error("pin A moved with no action");
  a_low_a: assert property (aMode == 3'h1 && $past(aMode) == 3'h1 |-> !$rose(timerPinAOut))
    else $error("pin A rose in low action");
  b_high_a: assert property (bMode == 3'h2 && $past(bMode) == 3'h2 |-> !$fell(timerPinBOut))
    else $error("pin B fell in high action");

  req_seen_c: cover property (overflowIrqRequest && eventIrqRequest != 4'h0);
  cap_mode_c: cover property (rdIo && regRdData[6] && regRdData[2]);
  pin_toggle_c: cover property (aMode == 3'h3 && $changed(timerPinAOut));
endmodule : ccs_timer_status_sva

bind ccs_timer_status ccs_timer_status_sva #(.AW(AW), .DW(DW)) i_ccs_timer_status_sva
(
  .clk(clk), .sysRst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .timerPinAIn(timerPinAIn), .timerPinAOut(timerPinAOut), .timerPinAOe(timerPinAOe),
  .timerPinBIn(timerPinBIn), .timerPinBOut(timerPinBOut), .timerPinBOe(timerPinBOe),
  .overflowIrqRequest(overflowIrqRequest), .eventIrqRequest(eventIrqRequest)
);

// >>> ccs_pin_partner.sv
// Purpose: Outside source on one capture/compare pin
// Assumes: Design enable high while it drives
// Notes:   No float: the source drives whenever the design lets go
`timescale 1ns/10ps

module ccs_pin_partner
(
  // Design side
  input  wire logic pinOut,
  input  wire logic pinOe,
  // Stimulus
  input  wire logic drive,
  // Line level
  output logic      pinIn
);
  assign pinIn = pinOe ? pinOut : drive;
endmodule : ccs_pin_partner

// >>> ccs_timer_status_test.sv
// Purpose: Self-checking bench for the timer status block
// Assumes: Reads answer one cycle later; pins sampled same cycle
// Notes:   Reads are scored from a queue of expected values
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end

module ccs_timer_status_test;
  import ccs_pkg::*;
  // ------------
  // Signals
  // ------------
  logic        clk = 1'b0;
  logic        sysRst = 1'b1;
  logic [2:0]  regAddr = 3'h0;
  logic [15:0] regWrData = 16'h0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [15:0] regRdData;
  logic        pinAIn, pinAOut, pinAOe, pinBIn, pinBOut, pinBOe;
  logic        drvA = 1'b0;
  logic        drvB = 1'b0;
  logic        ovfReq;
  logic [3:0]  evtReq;
  logic [15:0] expQ[$];
  logic [15:0] ev;
  logic [7:0]  en;
  logic        rdPend = 1'b0;
  int          mismatches = 0;
  int          compares = 0;
  ccs_action_t actT[6] = '{CCS_ACT_HIGH, CCS_ACT_LOW, CCS_ACT_HIGH, CCS_ACT_HIGH, CCS_ACT_TOGGLE, CCS_ACT_NONE};
  logic [5:0]  lvT = 6'b001101;
  ccs_edge_t   aEdg[3] = '{CCS_EDGE_RISE, CCS_EDGE_FALL, CCS_EDGE_BOTH};
  logic [1:0]  bEdg[3] = '{2'h0, 2'h1, 2'h3};

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  ccs_timer_status i_ccs_timer_status (.clk(clk), .sysRst(sysRst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .timerPinAIn(pinAIn), .timerPinAOut(pinAOut), .timerPinAOe(pinAOe), .timerPinBIn(pinBIn),
    .timerPinBOut(pinBOut), .timerPinBOe(pinBOe), .overflowIrqRequest(ovfReq), .eventIrqRequest(evtReq));
  ccs_pin_partner i_ccs_pin_partner_a (.pinOut(pinAOut), .pinOe(pinAOe), .drive(drvA), .pinIn(pinAIn));
  ccs_pin_partner i_ccs_pin_partner_b (.pinOut(pinBOut), .pinOe(pinBOe), .drive(drvB), .pinIn(pinBIn));

  // ------------
  // Bus tasks
  // ------------
  // Gap cycle after each strobe so no strobe is set twice in one step
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge clk);
    regWrite  <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    expQ.push_back(e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  always @(posedge clk)
  begin
    if (rdPend && expQ.size() > 0)
    begin
      ev = expQ.pop_front();
      `CHK("read data", ev, regRdData)
    end
    rdPend <= regRead;
  end

  // Run needs well under 1000 cycles; this allows 4000
  initial
  begin
    #20000;
    mismatches++;
    $display("watchdog expired");
    end_of_test();
  end

  // ------------
  // Tests
  // ------------
  initial
  begin
    void'($urandom(28));
    repeat (20) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    rd(3'h0, 16'h0070);
    rd(3'h1, 16'h0088);
    rd(3'h2, 16'h0070);
    for (int i = 4; i < 8; i++)
      rd(i[2:0], 16'hffff);
    $display("reset test done");
    wr(3'h3, 16'hfffd);
    rd(3'h3, 16'hfffe);
    tick(4);
    rd(3'h0, 16'h00ff);
    for (int k = 0; k < 3; k++)
    begin
      en = 8'($urandom);
      wr(3'h2, {8'h00, en});
      tick(1);
      `CHK("ovf request", en[7], ovfReq)
      `CHK("event request", en[3:0], evtReq)
      rd(3'h2, {8'h00, en[7], 3'h7, en[3:0]});
    end
    wr(3'h0, 16'h0080);
    rd(3'h0, 16'h00f0);
    wr(3'h0, 16'h0080);
    wr(3'h0, 16'h0000);
    rd(3'h0, 16'h00f0);
    wr(3'h0, 16'h0000);
    rd(3'h0, 16'h0070);
    $display("flag test done");
    for (int i = 0; i < 6; i++)
    begin
      wr(3'h1, {8'h00, 2'b00, actT[i], 2'b00, actT[i]});
      rd(3'h1, {8'h00, 2'b10, actT[i], 2'b10, actT[i]});
      wr(3'h4, 16'h1000);
      wr(3'h5, 16'h1000);
      wr(3'h3, 16'h0ff8);
      tick(12);
      `CHK("pin A", lvT[i], pinAOut)
      `CHK("pin B", lvT[i], pinBOut)
      `CHK("pin A enable", actT[i] != CCS_ACT_NONE, pinAOe)
      `CHK("pin B enable", actT[i] != CCS_ACT_NONE, pinBOe)
    end
    rd(3'h0, 16'h0073);
    $display("compare test done");
    for (int m = 0; m < 3; m++)
    begin
      drvA <= (m == 1);
      drvB <= (m == 1);
      wr(3'h1, {8'h00, 2'b01, bEdg[m], 2'b01, aEdg[m]});
      rd(3'h1, {8'h00, 2'b11, bEdg[m], 2'b11, aEdg[m]});
      wr(3'h3, 16'h2000);
      tick(4);
      drvA <= ~drvA;
      drvB <= ~drvB;
      tick(5);
      drvA <= ~drvA;
      drvB <= ~drvB;
      tick(3);
      rd(3'h4, (m == 2) ? 16'h200a : 16'h2005);
      rd(3'h5, (m == 2) ? 16'h200a : 16'h2005);
    end
    $display("capture test done");
    tick(5);
    end_of_test();
  end
endmodule : ccs_timer_status_test
